// ==== hdl/cpms_pkg.sv ====
// Purpose: Shared constants and types for the control port mode select block
// Assumes: Interface control register word is 16 bits, control link word is 24 bits
// Notes: Pin sample vector layout is fixed by the P_* indices below
package cpms_pkg;
  localparam int REG_W = 16;
  localparam int ADDR_W = 7;
  localparam int WORD_W = 24;
  localparam int HDR_W = 8;
  localparam int CNT_W = 5;
  localparam logic [6:0] IFC_ADDR = 7'h06;
  localparam logic [15:0] IFC_RESET = 16'h0200;
  localparam int CSEL_BIT = 1;
  localparam int SEP_BIT = 2;
  localparam int DRV_BIT = 3;
  localparam int AINC_BIT = 9;
  localparam int CLK_PERIOD_NS = 10;
  localparam int GLITCH_NS = 5;
  // Least time: round up, never below one cycle
  localparam int GLITCH_RAW = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GLITCH_CYC = (GLITCH_RAW < 1) ? 1 : GLITCH_RAW;
  // Synchronised input vector positions
  localparam int P_CS = 0;
  localparam int P_SCK = 1;
  localparam int P_SDA = 2;
  localparam int P_G10 = 3;
  localparam int P_G11 = 4;
  localparam int P_ACT = 5;
  localparam int P_BIT = 6;
  localparam int P_BT = 7;
  localparam int FLT_W = 5;
  localparam int SY_W = 9;
  localparam logic [1:0] STRAP_CNT = 2'h2;
  localparam logic [1:0] BOOT_DEV_CODE = 2'h1;
  localparam logic [1:0] BOOT_CUSTOM_CODE = 2'h2;

  typedef enum logic [1:0] {CPMS_TWO, CPMS_THREE, CPMS_FOUR} cpms_mode_type;
  typedef enum logic [1:0] {CPMS_BOOT_NORMAL, CPMS_BOOT_DEV, CPMS_BOOT_CUSTOM} cpms_boot_type;
  typedef logic [GLITCH_CYC-1:0] cpms_hist_type;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0] data;
  } cpms_wr_type;

  typedef struct packed {
    logic out;
    logic oe_n;
  } cpms_drv_type;
endpackage

// ==== hdl/cpms_top.sv ====
// Purpose: Control port mode select, pin borrowing and chip-select link word capture
// Assumes: serial_clk stands still while chip_select_n is high in chip-select modes
// Notes: Readback words are quasi-static across a frame; no read of other registers
`timescale 1ns/10ps
module cpms_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic serial_clk,
  input wire logic serial_data_io_in,
  output logic serial_data_io_out,
  output logic serial_data_io_oe_n,
  output logic general_pin_six_out,
  output logic general_pin_six_oe_n,
  input wire logic general_pin_seven_in,
  input wire logic general_pin_ten_in,
  input wire logic general_pin_eleven_in,
  output logic general_pin_eleven_out,
  output logic general_pin_eleven_oe_n,
  input wire logic [1:0] boot_option_pins,
  input wire logic normal_op_sel,
  input wire cpms_pkg::cpms_drv_type gpio_six_drv,
  input wire logic tw_busy,
  input wire logic tw_sda_low,
  input wire cpms_pkg::cpms_wr_type tw_wr,
  output logic tw_scl,
  output logic tw_sda,
  output logic auto_inc_en,
  output cpms_pkg::cpms_mode_type link_mode,
  output logic sec_bus_active,
  output logic gp7_as_cs,
  output cpms_pkg::cpms_wr_type link_wr
);

  typedef struct packed {
    logic [cpms_pkg::SY_W-1:0] sy1;
    logic [cpms_pkg::SY_W-1:0] sy2;
    cpms_pkg::cpms_hist_type [cpms_pkg::FLT_W-1:0] hist;
    logic [cpms_pkg::FLT_W-1:0] filt;
    logic [1:0] strap_cnt;
    cpms_pkg::cpms_boot_type boot;
    logic sec;
    logic [cpms_pkg::REG_W-1:0] ifc;
    cpms_pkg::cpms_mode_type mode;
    logic drv_od;
    logic ainc;
    logic gp7_cs;
    cpms_pkg::cpms_wr_type wr;
    cpms_pkg::cpms_drv_type sda;
    cpms_pkg::cpms_drv_type gp6;
    cpms_pkg::cpms_drv_type g11;
    logic tw_scl;
    logic tw_sda;
  } cpms_ref_type;

  typedef struct packed {
    logic [cpms_pkg::CNT_W-1:0] cnt;
    logic rd_act;
    logic [cpms_pkg::REG_W-1:0] rd_sh;
  } cpms_link_type;

  cpms_ref_type q;
  cpms_ref_type d;
  cpms_link_type lq;
  cpms_link_type ld;
  logic [cpms_pkg::WORD_W-1:0] link_shift_q;
  logic link_rst;
  logic cs_rise;
  logic idle;
  logic act;
  logic rd_bit;
  logic [cpms_pkg::HDR_W-2:0] rd_addr;
  logic [cpms_pkg::REG_W-1:0] wr_data;

  // Link side: the frame's own select pin ends the read, so a stopped clock is harmless
  // It also parks the link side while two-line mode owns the pins
  assign link_rst = general_pin_seven_in | ~q.gp7_cs;
  assign rd_addr = {link_shift_q[cpms_pkg::ADDR_W-2:0], serial_data_io_in};

  // Shift register keeps the last word; stable once the clock stops
  always_ff @(posedge serial_clk) begin
    link_shift_q <= {link_shift_q[cpms_pkg::WORD_W-2:0], serial_data_io_in};
  end

  always_comb begin
    ld = lq;
    if (lq.cnt != cpms_pkg::CNT_W'(cpms_pkg::WORD_W)) begin
      ld.cnt = lq.cnt + 5'h01;
    end
    if (lq.cnt == cpms_pkg::CNT_W'(cpms_pkg::HDR_W - 1)) begin
      // Eighth bit arriving: header complete, load readback word
      ld.rd_act = link_shift_q[cpms_pkg::HDR_W-2];
      ld.rd_sh = (rd_addr == cpms_pkg::IFC_ADDR) ? q.ifc : '0;
    end else if (lq.rd_act) begin
      ld.rd_sh = {lq.rd_sh[cpms_pkg::REG_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge serial_clk or posedge link_rst) begin
    if (link_rst) begin
      lq <= '0;
    end else begin
      lq <= ld;
    end
  end

  // Reference side
  assign act = q.sy2[cpms_pkg::P_ACT];
  assign rd_bit = q.sy2[cpms_pkg::P_BIT];
  assign idle = (q.mode == cpms_pkg::CPMS_TWO) ? ~tw_busy : q.filt[cpms_pkg::P_CS];
  assign wr_data = link_shift_q[cpms_pkg::REG_W-1:0];

  always_comb begin
    d = q;
    d.sy1 = {boot_option_pins, lq.rd_sh[cpms_pkg::REG_W-1], lq.rd_act, general_pin_eleven_in,
             general_pin_ten_in, serial_data_io_in, serial_clk, general_pin_seven_in};
    d.sy2 = q.sy1;
    // A value is taken only after it held for longer than the suppressed spike
    for (int i = 0; i < cpms_pkg::FLT_W; i++) begin
      d.hist[i] = cpms_pkg::cpms_hist_type'({q.hist[i], q.sy2[i]});
      if (&{q.hist[i], q.sy2[i]} || ~|{q.hist[i], q.sy2[i]}) begin
        d.filt[i] = q.sy2[i];
      end
    end
    cs_rise = d.filt[cpms_pkg::P_CS] & ~q.filt[cpms_pkg::P_CS];

    // Boot strap taken once the synchroniser holds the pin value
    d.sec = q.sec & ~normal_op_sel;
    if (q.strap_cnt != 2'h3) begin
      d.strap_cnt = q.strap_cnt + 2'h1;
    end
    if (q.strap_cnt == cpms_pkg::STRAP_CNT) begin
      if (q.sy2[cpms_pkg::P_BT+:2] == cpms_pkg::BOOT_DEV_CODE) begin
        d.boot = cpms_pkg::CPMS_BOOT_DEV;
        d.sec = 1'b1;
      end else if (q.sy2[cpms_pkg::P_BT+:2] == cpms_pkg::BOOT_CUSTOM_CODE) begin
        d.boot = cpms_pkg::CPMS_BOOT_CUSTOM;
        d.sec = 1'b0;
      end else begin
        d.boot = cpms_pkg::CPMS_BOOT_NORMAL;
        d.sec = 1'b0;
      end
    end

    // Word latched on the rising select edge; write words only
    d.wr.valid = 1'b0;
    if (cs_rise && q.gp7_cs && !link_shift_q[cpms_pkg::WORD_W-1]) begin
      d.wr.valid = 1'b1;
      d.wr.addr = link_shift_q[cpms_pkg::WORD_W-2:cpms_pkg::REG_W];
      d.wr.data = wr_data;
    end
    // A link write wins over a two-line write in the same cycle
    if (d.wr.valid && d.wr.addr == cpms_pkg::IFC_ADDR) begin
      d.ifc = d.wr.data;
    end else if (tw_wr.valid && tw_wr.addr == cpms_pkg::IFC_ADDR) begin
      d.ifc = tw_wr.data;
    end
    d.ainc = d.ifc[cpms_pkg::AINC_BIT];

    // Mode follows the register only between frames
    if (idle) begin
      if (!q.ifc[cpms_pkg::CSEL_BIT]) begin
        d.mode = cpms_pkg::CPMS_TWO;
      end else if (q.ifc[cpms_pkg::SEP_BIT]) begin
        d.mode = cpms_pkg::CPMS_FOUR;
      end else begin
        d.mode = cpms_pkg::CPMS_THREE;
      end
      d.drv_od = q.ifc[cpms_pkg::DRV_BIT];
    end
    // Pin seven follows the mode that takes effect at this edge
    d.gp7_cs = (d.mode != cpms_pkg::CPMS_TWO);

    // Serial data line: open-drain, drives low only
    d.sda.out = 1'b0;
    d.sda.oe_n = ~((q.mode == cpms_pkg::CPMS_TWO && !q.sec && tw_sda_low) ||
                   (q.mode == cpms_pkg::CPMS_THREE && act && !rd_bit));
    // Secondary data pin is open-drain like the primary line
    d.g11.out = 1'b0;
    d.g11.oe_n = ~(q.mode == cpms_pkg::CPMS_TWO && q.sec && tw_sda_low);
    // Push-pull holds the output low between reads; open-drain lets it float
    if (q.mode == cpms_pkg::CPMS_FOUR) begin
      if (q.drv_od) begin
        d.gp6.out = 1'b0;
        d.gp6.oe_n = ~(act && !rd_bit);
      end else begin
        d.gp6.out = act & rd_bit;
        d.gp6.oe_n = 1'b0;
      end
    end else begin
      d.gp6 = gpio_six_drv;
    end

    // Two-line engine sees an idle bus outside two-line mode
    d.tw_scl = 1'b1;
    d.tw_sda = 1'b1;
    if (q.mode == cpms_pkg::CPMS_TWO) begin
      d.tw_scl = q.sec ? q.filt[cpms_pkg::P_G10] : q.filt[cpms_pkg::P_SCK];
      d.tw_sda = q.sec ? q.filt[cpms_pkg::P_G11] : q.filt[cpms_pkg::P_SDA];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      q <= '0;
      q.sy1 <= '1;
      q.sy2 <= '1;
      q.hist <= '1;
      q.filt <= '1;
      q.ifc <= cpms_pkg::IFC_RESET;
      q.ainc <= cpms_pkg::IFC_RESET[cpms_pkg::AINC_BIT];
      q.sda.oe_n <= 1'b1;
      q.gp6.oe_n <= 1'b1;
      q.g11.oe_n <= 1'b1;
      q.tw_scl <= 1'b1;
      q.tw_sda <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign serial_data_io_out = q.sda.out;
  assign serial_data_io_oe_n = q.sda.oe_n;
  assign general_pin_six_out = q.gp6.out;
  assign general_pin_six_oe_n = q.gp6.oe_n;
  assign general_pin_eleven_out = q.g11.out;
  assign general_pin_eleven_oe_n = q.g11.oe_n;
  assign tw_scl = q.tw_scl;
  assign tw_sda = q.tw_sda;
  assign auto_inc_en = q.ainc;
  assign link_mode = q.mode;
  assign sec_bus_active = q.sec;
  assign gp7_as_cs = q.gp7_cs;
  assign link_wr = q.wr;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  gp7_select_a: assert property (
    $changed(q.mode) |-> q.gp7_cs == (q.mode != cpms_pkg::CPMS_TWO))
    else $error("pin seven ownership disagrees with mode");

  gp6_owned_a: assert property (
    (q.mode == cpms_pkg::CPMS_FOUR && !q.drv_od) |=> !general_pin_six_oe_n)
    else $error("pin six not driven in four-line push-pull");

  sda_route_a: assert property (
    (q.mode == cpms_pkg::CPMS_FOUR) [*2] |-> serial_data_io_oe_n)
    else $error("serial data driven in four-line mode");

  ainc_follow_a: assert property (
    (tw_wr.valid && tw_wr.addr == cpms_pkg::IFC_ADDR && !d.wr.valid)
      |=> auto_inc_en == $past(tw_wr.data[cpms_pkg::AINC_BIT]))
    else $error("auto-increment did not follow write");

  no_sec_custom_a: assert property (
    (q.boot == cpms_pkg::CPMS_BOOT_CUSTOM) |-> !sec_bus_active && general_pin_eleven_oe_n)
    else $error("secondary bus active in custom boot");

  sec_dev_a: assert property (
    (q.strap_cnt == cpms_pkg::STRAP_CNT && q.sy2[cpms_pkg::P_BT+:2] == cpms_pkg::BOOT_DEV_CODE
     && !normal_op_sel) |=> sec_bus_active)
    else $error("development boot did not select secondary bus");

  od_release_a: assert property (
    (q.mode == cpms_pkg::CPMS_FOUR && q.drv_od && !act) |=> general_pin_six_oe_n)
    else $error("open-drain output driven while idle");

  drv_ignored_a: assert property (
    (q.mode != cpms_pkg::CPMS_FOUR) |=> {general_pin_six_out, general_pin_six_oe_n}
      == $past(gpio_six_drv))
    else $error("driver select leaked outside four-line mode");

  glitch_hold_a: assert property (
    $changed(q.filt[cpms_pkg::P_CS]) |-> $past(q.sy2[cpms_pkg::P_CS], 1)
      == $past(q.sy2[cpms_pkg::P_CS], 2))
    else $error("select changed on a single sample");

  mode_idle_a: assert property (
    $changed(q.mode) |-> $past(idle) && $past(q.ifc[cpms_pkg::CSEL_BIT])
      == (q.mode != cpms_pkg::CPMS_TWO))
    else $error("mode changed mid-frame or against select bit");

  four_needs_sel_a: assert property (
    (q.mode == cpms_pkg::CPMS_FOUR && $changed(q.mode))
      |-> $past(q.ifc[cpms_pkg::CSEL_BIT] && q.ifc[cpms_pkg::SEP_BIT]))
    else $error("four-line entered without both select bits");

  word_latch_a: assert property (
    (cs_rise && q.gp7_cs && !link_shift_q[cpms_pkg::WORD_W-1])
      |=> link_wr.valid ##1 !link_wr.valid)
    else $error("write word not latched as one pulse");

  // Pin ownership and idle levels in each mode, and the boot strap hold
  pp_idle_low_a: assert property (
    (q.mode == cpms_pkg::CPMS_FOUR && !q.drv_od && !act) |=> !general_pin_six_out)
    else $error("push-pull read output not low while idle");

  three_read_a: assert property (
    (q.mode == cpms_pkg::CPMS_THREE && act && !rd_bit) |=> !serial_data_io_oe_n)
    else $error("three-line read bit zero not driven on data line");

  cs_pin_free_a: assert property (
    (link_mode == cpms_pkg::CPMS_TWO) |-> !gp7_as_cs)
    else $error("pin seven held as select in two-line mode");

  tw_parked_a: assert property (
    (q.mode != cpms_pkg::CPMS_TWO) |=> tw_scl && tw_sda)
    else $error("two-line engine saw pin activity outside two-line mode");

  boot_once_a: assert property (
    (q.strap_cnt == 2'h3) |=> $stable(q.boot))
    else $error("boot option changed after strap sampling");

  sec_release_a: assert property (
    (normal_op_sel && q.strap_cnt == 2'h3) |=> !sec_bus_active)
    else $error("secondary bus kept after normal operation chosen");

  g11_parked_a: assert property (
    !sec_bus_active |=> general_pin_eleven_oe_n)
    else $error("secondary data pin driven without secondary bus");

  // Main scenarios: reads in three- and four-line modes, boot release, register write
  four_read_c: cover property (q.mode == cpms_pkg::CPMS_FOUR && act ##[1:40] !act);
  dev_boot_c: cover property ($rose(sec_bus_active) ##[1:300] $fell(sec_bus_active));
  frame_wr_c: cover property (link_wr.valid && link_wr.addr == cpms_pkg::IFC_ADDR);
  three_read_c: cover property (q.mode == cpms_pkg::CPMS_THREE && act && !rd_bit);
  od_read_c: cover property (q.mode == cpms_pkg::CPMS_FOUR && q.drv_od && !general_pin_six_oe_n);

endmodule // cpms_top

// ==== bench/cpms_host_model.sv ====
// Purpose: Host model driving the chip-select control link
// Assumes: Serial clock idles high and stands still outside frames
// Notes: A read bit is taken at the rising edge after it is launched
`timescale 1ns/10ps
module cpms_host_model (
  output logic sclk,
  output logic cs_n,
  output logic sda_oe,
  output logic sda_val,
  input wire logic rd_in
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    sda_oe = 1'b0;
    sda_val = 1'b0;
  end
  // One whole word, MSB first, latched by the rising select
  task automatic xfer(input logic [23:0] word, output logic [15:0] rd);
    rd = 16'h0000;
    cs_n = 1'b0;
    #48;
    for (int i = 23; i >= 0; i--) begin
      sclk = 1'b0;
      sda_oe = !(word[23] && i < 16);
      sda_val = word[i];
      #32;
      if (i < 16) rd[i] = rd_in;
      sclk = 1'b1;
      #32;
    end
    cs_n = 1'b1;
    sda_oe = 1'b0;
  endtask
endmodule // cpms_host_model

// ==== bench/test_control_port_mode_select.sv ====
// Purpose: Self-checking bench for the control port mode select block
// Assumes: Data line, pin six and pin eleven float high through pull-ups
// Notes: Link clock comes from the host model at 64 ns, only inside frames
`timescale 1ns/10ps
module test_control_port_mode_select;
  logic ref_clk, rst_n, glitch_n, g10, nrm, busy, sda_low, use_six;
  logic [1:0] boot;
  cpms_pkg::cpms_drv_type six_drv;
  cpms_pkg::cpms_wr_type tw_wr, lwr;
  cpms_pkg::cpms_mode_type mode;
  logic sclk, cs_n, h_oe, h_val, sda_out, sda_oe_n, six_out, six_oe_n;
  logic g11_out, g11_oe_n, tw_scl, tw_sda, ainc, sec, gp7;
  int err_total, comparisons;
  wire logic sda_w = (h_oe ? h_val : 1'b1) & (sda_oe_n | sda_out) & glitch_n;
  wire logic six_w = six_oe_n | six_out;
  wire logic g11_w = g11_oe_n | g11_out;
  wire logic rd_w = use_six ? six_w : sda_w;

  cpms_host_model u_host (.sclk(sclk), .cs_n(cs_n), .sda_oe(h_oe), .sda_val(h_val),
    .rd_in(rd_w));
  cpms_top u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .serial_clk(sclk),
    .serial_data_io_in(sda_w), .serial_data_io_out(sda_out),
    .serial_data_io_oe_n(sda_oe_n), .general_pin_six_out(six_out),
    .general_pin_six_oe_n(six_oe_n), .general_pin_seven_in(cs_n),
    .general_pin_ten_in(g10), .general_pin_eleven_in(g11_w),
    .general_pin_eleven_out(g11_out), .general_pin_eleven_oe_n(g11_oe_n),
    .boot_option_pins(boot), .normal_op_sel(nrm), .gpio_six_drv(six_drv),
    .tw_busy(busy), .tw_sda_low(sda_low), .tw_wr(tw_wr), .tw_scl(tw_scl),
    .tw_sda(tw_sda), .auto_inc_en(ainc), .link_mode(mode), .sec_bus_active(sec),
    .gp7_as_cs(gp7), .link_wr(lwr));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish;
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic do_reset(input logic [1:0] b);
    cyc(1);
    rst_n = 1'b0;
    boot = b;
    cyc(16);
    rst_n = 1'b1;
    cyc(8);
  endtask

  task automatic tw_write(input logic [15:0] d);
    tw_wr = {1'b1, cpms_pkg::IFC_ADDR, d};
    cyc(1);
    tw_wr.valid = 1'b0;
    cyc(3);
  endtask

  // One frame, then a bounded look for the captured write word
  task automatic link(input logic [23:0] w, input logic [15:0] exp_rd);
    logic [15:0] rd;
    logic got;
    got = 1'b0;
    #3;
    u_host.xfer(w, rd);
    repeat (12) begin
      @(negedge ref_clk);
      if (lwr.valid === 1'b1) begin
        got = 1'b1;
        chk("link word", {9'h000, lwr.addr, lwr.data}, {9'h000, w[22:0]});
      end
    end
    chk("link write seen", got, !w[23]);
    if (w[23]) chk("read data", rd, exp_rd);
  endtask

  task automatic t_reset;
    chk("mode", mode, cpms_pkg::CPMS_TWO);
    chk("cs pin", gp7, 1'b0);
    chk("auto inc", ainc, 1'b1);
    chk("secondary", sec, 1'b0);
    chk("tw clock", tw_scl, 1'b1);
    chk("data oe", sda_oe_n, 1'b1);
    chk("pin six oe", six_oe_n, 1'b1);
    chk("link write", lwr.valid, 1'b0);
  endtask

  // The block's own drive is seen back through the filter, so the glitch waits for a quiet line
  task automatic t_two;
    sda_low = 1'b1;
    cyc(2);
    chk("ack drive", sda_oe_n, 1'b0);
    cyc(5);
    chk("ack seen", tw_sda, 1'b0);
    sda_low = 1'b0;
    cyc(8);
    chk("line free", tw_sda, 1'b1);
    #2 glitch_n = 1'b0;
    #5 glitch_n = 1'b1;
    repeat (4) begin
      cyc(1);
      chk("glitch", tw_sda, 1'b1);
    end
    busy = 1'b1;
    tw_write(16'h0002);
    chk("auto inc off", ainc, 1'b0);
    chk("held mode", mode, cpms_pkg::CPMS_TWO);
    busy = 1'b0;
    cyc(4);
    chk("three line", {mode, gp7}, 3'b011);
  endtask

  task automatic t_link;
    link({1'b0, 7'h06, 16'h0206}, 16'h0000);
    chk("four line", mode, cpms_pkg::CPMS_FOUR);
    chk("six idle push pull", {six_out, six_oe_n}, 2'b00);
    use_six = 1'b1;
    link({1'b1, 7'h06, 16'h0000}, 16'h0206);
    link({1'b1, 7'h05, 16'h0000}, 16'h0000);
    link({1'b0, 7'h06, 16'h020E}, 16'h0000);
    chk("six idle open drain", six_oe_n, 1'b1);
    link({1'b1, 7'h06, 16'h0000}, 16'h020E);
    six_drv = 2'b10;
    link({1'b0, 7'h06, 16'h020A}, 16'h0000);
    chk("back to three", mode, cpms_pkg::CPMS_THREE);
    chk("six own function", {six_out, six_oe_n}, 2'b10);
    use_six = 1'b0;
    link({1'b1, 7'h06, 16'h0000}, 16'h020A);
    link({1'b0, 7'h06, 16'h0200}, 16'h0000);
    chk("back to two", {mode, gp7}, 3'b000);
  endtask

  task automatic t_boot;
    do_reset(cpms_pkg::BOOT_DEV_CODE);
    chk("dev secondary", sec, 1'b1);
    g10 = 1'b0;
    sda_low = 1'b1;
    cyc(6);
    chk("secondary clock", tw_scl, 1'b0);
    chk("secondary data", {g11_oe_n, sda_oe_n}, 2'b01);
    chk("secondary line", g11_w, 1'b0);
    chk("secondary data in", tw_sda, 1'b0);
    g10 = 1'b1;
    nrm = 1'b1;
    cyc(6);
    chk("released", sec, 1'b0);
    do_reset(cpms_pkg::BOOT_CUSTOM_CODE);
    chk("custom secondary", {sec, g11_oe_n}, 2'b01);
    sda_low = 1'b0;
  endtask

  initial begin
    rst_n = 1'b0;
    boot = 2'h0;
    glitch_n = 1'b1;
    g10 = 1'b1;
    nrm = 1'b0;
    busy = 1'b0;
    sda_low = 1'b0;
    use_six = 1'b0;
    six_drv = 2'b01;
    tw_wr = '0;
    err_total = 0;
    comparisons = 0;
    do_reset(2'h0);
    t_reset();
    t_two();
    t_link();
    t_boot();
    tally_and_finish();
  end

  // Frames take about 2 us each; this span is over twenty times the whole run
  initial begin
    #400000;
    err_total++;
    tally_and_finish();
  end
endmodule // test_control_port_mode_select
